// ### pkg/lmdt_pkg.sv
// Shared types and constants of the multiplexed LCD display timing block.
package lmdt_pkg;

    // ==========================================================
    // Geometry of the display memory.
    localparam int NUM_SEG = 40;
    localparam int NUM_ROW = 4;
    localparam logic [5:0] LAST_COL = 6'h27;

    // ==========================================================
    // Timing: frame rate is the selected clock divided by FRAME_DIV.
    localparam int FRAME_DIV = 24;
    localparam logic [3:0] HALF_TICKS = 4'(FRAME_DIV / 2);
    localparam int CLK_PERIOD_NS = 10;
    // Internal oscillator period; the value is a plain default.
    localparam int OSC_PERIOD_NS = 320;
    localparam logic [7:0] OSC_HALF_CYCLES =
        8'(OSC_PERIOD_NS / (2 * CLK_PERIOD_NS));

    // ==========================================================
    // Drive modes, bias and output level codes.
    typedef enum logic [1:0] {
        MODE_STATIC = 2'h0,
        MODE_1TO2 = 2'h1,
        MODE_1TO3 = 2'h2,
        MODE_1TO4 = 2'h3
    } lmdt_mode_type;

    typedef enum logic [2:0] {
        LV_SS = 3'h0,
        LV_THIRD = 3'h1,
        LV_HALF = 3'h2,
        LV_TWOTHIRD = 3'h3,
        LV_LCD = 3'h4
    } lmdt_level_type;

    typedef struct packed {
        lmdt_mode_type mode;
        logic halfBias;
    } lmdt_cfg_type;

    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] data;
    } lmdt_wr_type;

    localparam lmdt_cfg_type CFG_RESET = '{mode: MODE_1TO4, halfBias: 1'b0};

endpackage

// ### verilog/lmdt_display_timing.sv
// Timing, display RAM and level selection of the segment LCD driver.
`timescale 1ns/1ps

module lmdt_display_timing (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clock_source_select_pin,
    input wire logic clkLineIn,
    output logic clkLineOut,
    output logic clkLineOe_n,
    input wire logic syncIn,
    output logic syncOut,
    output logic syncOe_n,
    input wire logic cfgValid,
    input wire lmdt_pkg::lmdt_cfg_type cfgIn,
    input wire logic wrValid,
    input wire lmdt_pkg::lmdt_wr_type wrIn,
    output lmdt_pkg::lmdt_level_type backplane_outputs [4],
    output lmdt_pkg::lmdt_level_type segment_outputs [40],
    output logic frameSignal
);
    import lmdt_pkg::*;

    // ==========================================================
    // Helper functions.

    // Number of scanned rows for a mode.
    function automatic logic [2:0] rowsOf(input lmdt_mode_type m);
        unique case (m)
            MODE_STATIC: rowsOf = 3'h1;
            MODE_1TO2: rowsOf = 3'h2;
            MODE_1TO3: rowsOf = 3'h3;
            MODE_1TO4: rowsOf = 3'h4;
        endcase
    endfunction

    // Logical row shown on a backplane pin; mirrored pins share a row.
    function automatic logic [1:0] bpRow(input logic [1:0] pin,
                                         input lmdt_mode_type m);
        unique case (m)
            MODE_STATIC: bpRow = 2'h0;
            MODE_1TO2: bpRow = {1'b0, pin[0]};
            MODE_1TO3: bpRow = (pin == 2'h3) ? 2'h1 : pin;
            MODE_1TO4: bpRow = pin;
        endcase
    endfunction

    // Backplane level: active row drives the extreme, others a bias level.
    function automatic lmdt_level_type bpCode(input logic act,
        input logic pol, input lmdt_cfg_type c);
        if (act || c.mode == MODE_STATIC) begin
            bpCode = pol ? LV_SS : LV_LCD;
        end else if (c.halfBias) begin
            bpCode = LV_HALF;
        end else begin
            bpCode = pol ? LV_TWOTHIRD : LV_THIRD;
        end
    endfunction

    // Segment level: an on element sees the opposite extreme of its row.
    function automatic lmdt_level_type segCode(input logic on,
        input logic pol, input lmdt_cfg_type c);
        if (on) begin
            segCode = pol ? LV_LCD : LV_SS;
        end else if (c.mode == MODE_STATIC) begin
            segCode = pol ? LV_SS : LV_LCD;
        end else if (c.halfBias) begin
            segCode = LV_HALF;
        end else begin
            segCode = pol ? LV_THIRD : LV_TWOTHIRD;
        end
    endfunction

    // ==========================================================
    // Pin synchronisers: the first stage feeds only the second.
    logic selMeta, selSync;
    logic clkMeta, clkSync, clkPrev;
    logic syncMeta, syncSync, syncPrev;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            selMeta <= 1'b0;
            selSync <= 1'b0;
            clkMeta <= 1'b0;
            clkSync <= 1'b0;
            clkPrev <= 1'b0;
            syncMeta <= 1'b1;
            syncSync <= 1'b1;
            syncPrev <= 1'b1;
        end else begin
            selMeta <= clock_source_select_pin;
            selSync <= selMeta;
            clkMeta <= clkLineIn;
            clkSync <= clkMeta;
            clkPrev <= clkSync;
            syncMeta <= syncIn;
            syncSync <= syncMeta;
            syncPrev <= syncSync;
        end
    end

    // ==========================================================
    // Internal oscillator, divided down from the system clock.
    logic [7:0] oscCnt;
    logic oscLevel;
    logic oscTick;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            oscCnt <= 8'h00;
            oscLevel <= 1'b0;
        end else if (oscCnt == OSC_HALF_CYCLES - 8'h01) begin
            oscCnt <= 8'h00;
            oscLevel <= !oscLevel;
        end else begin
            oscCnt <= oscCnt + 8'h01;
        end
    end

    // One tick per rising edge of the selected clock source.
    assign oscTick = (oscCnt == OSC_HALF_CYCLES - 8'h01) && !oscLevel;
    logic tick;
    assign tick = selSync ? (clkSync && !clkPrev) : oscTick;

    // The line is driven only while the internal oscillator is chosen.
    assign clkLineOut = oscLevel;
    assign clkLineOe_n = selSync;

    // ==========================================================
    // Drive configuration, taken from the decoded command.
    lmdt_cfg_type cfg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= CFG_RESET;
        end else if (cfgValid) begin
            cfg <= cfgIn;
        end
    end

    // ==========================================================
    // Multiplex sequencer: slot length times rows is half a frame.
    logic [3:0] tickCnt;
    logic [1:0] row;
    logic pol;
    logic slotEnd, halfEnd, realign, ownSlot, loadNow;
    logic [3:0] slotLen;

    assign slotLen = HALF_TICKS / {1'b0, rowsOf(cfg.mode)};
    assign slotEnd = tick && (tickCnt == slotLen - 4'h1);
    assign halfEnd = slotEnd && ({1'b0, row} == rowsOf(cfg.mode) - 3'h1);
    assign ownSlot = (row == 2'h0) && !pol;
    // A falling sync seen outside our own first slot means we are late.
    assign realign = cfgValid || (!syncSync && syncPrev && !ownSlot);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tickCnt <= 4'h0;
            row <= 2'h0;
            pol <= 1'b0;
        end else if (realign) begin
            tickCnt <= 4'h0;
            row <= 2'h0;
            pol <= 1'b0;
        end else if (slotEnd) begin
            tickCnt <= 4'h0;
            row <= halfEnd ? 2'h0 : row + 2'h1;
            pol <= halfEnd ? !pol : pol;
        end else if (tick) begin
            tickCnt <= tickCnt + 4'h1;
        end
    end

    // Pull the shared sync line low for the first slot of every frame.
    assign syncOut = 1'b0;
    assign syncOe_n = !ownSlot;

    // ==========================================================
    // Display RAM, written byte by byte in the mode's packing.
    logic [3:0] ram [NUM_SEG];

    always_ff @(posedge clk or negedge rst_n) begin
        logic [6:0] col;
        logic [1:0] r;
        if (!rst_n) begin
            for (int c = 0; c < NUM_SEG; c++) begin
                ram[c] <= 4'h0;
            end
        end else if (wrValid) begin
            for (int i = 0; i < 8; i++) begin
                unique case (cfg.mode)
                    MODE_STATIC: begin
                        col = 7'(i);
                        r = 2'h0;
                    end
                    MODE_1TO2: begin
                        col = 7'(i / 2);
                        r = 2'(i % 2);
                    end
                    MODE_1TO3: begin
                        col = 7'(i / 3);
                        r = 2'(i % 3);
                    end
                    MODE_1TO4: begin
                        col = 7'(i / 4);
                        r = 2'(i % 4);
                    end
                endcase
                col = col + {1'b0, wrIn.addr};
                // Bits past the last column are dropped, not wrapped.
                if (col <= {1'b0, LAST_COL}) begin
                    ram[col[5:0]][r] <= wrIn.data[7 - i];
                end
            end
        end
    end

    // ==========================================================
    // Display register, loaded once per slot and held through it.
    logic [NUM_SEG-1:0] dispReg;
    logic [1:0] outRow;
    logic outPol;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            loadNow <= 1'b1;
        end else begin
            loadNow <= slotEnd || realign;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dispReg <= '0;
            outRow <= 2'h0;
            outPol <= 1'b0;
        end else if (loadNow) begin
            for (int c = 0; c < NUM_SEG; c++) begin
                dispReg[c] <= ram[c][row];
            end
            outRow <= row;
            outPol <= pol;
        end
    end

    // ==========================================================
    // Output level selection, registered; every backplane and segment output shows VLCD in reset.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int b = 0; b < NUM_ROW; b++) begin
                backplane_outputs[b] <= LV_LCD;
            end
            for (int c = 0; c < NUM_SEG; c++) begin
                segment_outputs[c] <= LV_LCD;
            end
            frameSignal <= 1'b0;
        end else begin
            for (int b = 0; b < NUM_ROW; b++) begin
                backplane_outputs[b] <= bpCode(
                    bpRow(2'(b), cfg.mode) == outRow, outPol, cfg);
            end
            for (int c = 0; c < NUM_SEG; c++) begin
                segment_outputs[c] <= segCode(dispReg[c], outPol, cfg);
            end
            frameSignal <= outPol;
        end
    end

    // ==========================================================
    // Checks. Helper logic counts ticks per frame half.
    logic [4:0] halfTicks;
    logic halfClean, cfgSeen;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            halfTicks <= 5'h00;
            halfClean <= 1'b0;
            cfgSeen <= 1'b0;
        end else begin
            cfgSeen <= cfgSeen || cfgValid;
            if (realign) begin
                halfTicks <= 5'h00;
                halfClean <= 1'b0;
            end else if (halfEnd) begin
                halfTicks <= 5'h00;
                halfClean <= 1'b1;
            end else if (tick) begin
                halfTicks <= halfTicks + 5'h01;
            end
        end
    end

    reset_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
        !cfgSeen |-> cfg == CFG_RESET)
        else $error("Mode after reset is not 1:4 third bias.");

    frame_half_a: assert property (@(posedge clk) disable iff (!rst_n)
        (halfEnd && halfClean && !realign) |-> halfTicks == 5'd11)
        else $error("Frame half is not twelve clock ticks.");

    ext_clock_a: assert property (@(posedge clk) disable iff (!rst_n)
        selSync |-> clkLineOe_n && (tick == (clkSync && !clkPrev)))
        else $error("External clock not taken from clock line.");

    osc_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!selSync && oscTick) ##1 !selSync |-> !clkLineOe_n && clkLineOut)
        else $error("Oscillator clock not driven on clock line.");

    mirror_13_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg.mode == MODE_1TO3 && $past(cfg.mode) == MODE_1TO3)
        |-> backplane_outputs[3] == backplane_outputs[1])
        else $error("Backplane 3 differs from 1 in 1:3 mode.");

    mirror_12_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg.mode == MODE_1TO2 && $past(cfg.mode) == MODE_1TO2)
        |-> backplane_outputs[2] == backplane_outputs[0]
        && backplane_outputs[3] == backplane_outputs[1])
        else $error("Paired backplanes differ in 1:2 mode.");

    static_bp_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg.mode == MODE_STATIC && $past(cfg.mode) == MODE_STATIC)
        |-> backplane_outputs[1] == backplane_outputs[0]
        && backplane_outputs[2] == backplane_outputs[0]
        && backplane_outputs[3] == backplane_outputs[0])
        else $error("Backplanes differ in static mode.");

    seg_on_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg.mode == MODE_STATIC && $past(cfg.mode) == MODE_STATIC)
        |-> (segment_outputs[0] != backplane_outputs[0])
        == $past(dispReg[0]))
        else $error("Static segment state does not follow its bit.");

    ram_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wrValid && cfg.mode == MODE_1TO4 && wrIn.addr < LAST_COL)
        |=> {ram[$past(wrIn.addr)][0], ram[$past(wrIn.addr)][1],
            ram[$past(wrIn.addr)][2], ram[$past(wrIn.addr)][3]}
        == $past(wrIn.data[7:4])
        && {ram[$past(wrIn.addr) + 6'h01][0],
            ram[$past(wrIn.addr) + 6'h01][1],
            ram[$past(wrIn.addr) + 6'h01][2],
            ram[$past(wrIn.addr) + 6'h01][3]} == $past(wrIn.data[3:0]))
        else $error("Display byte not stored on arrival.");

    row_order_a: assert property (@(posedge clk) disable iff (!rst_n)
        (slotEnd && !halfEnd && !realign) |=> row == $past(row) + 2'h1)
        else $error("Row scan is out of order.");

endmodule

// ### tb/lmdt_panel_model.sv
// Behavioural model of the LCD panel, probed at one element.
`timescale 1ns/1ps

module lmdt_panel_model (
    input wire lmdt_pkg::lmdt_level_type backplanes [4],
    input wire lmdt_pkg::lmdt_level_type segments [40],
    input wire logic [1:0] probeRow,
    input wire logic [5:0] probeCol,
    output logic [2:0] voltsAcross
);
    import lmdt_pkg::*;

    // ==========================================================
    // Element voltage
    // An element sits where a backplane row crosses a segment column.
    // Only the magnitude is kept, since the liquid sees both signs alike.
    always_comb begin
        if (backplanes[probeRow] > segments[probeCol]) begin
            voltsAcross = 3'(backplanes[probeRow] - segments[probeCol]);
        end else begin
            voltsAcross = 3'(segments[probeCol] - backplanes[probeRow]);
        end
    end
endmodule

// ### tb/tb_top.sv
// Self-checking testbench of the multiplexed LCD display timing block.
`timescale 1ns/1ps

module tb_top;
    import lmdt_pkg::*;

    // ==========================================================
    // Signals
    logic clk, rst_n, selPin, extOn, tbSyncLow, cfgValid, wrValid;
    // The external source is owned by its generator process alone.
    logic extClk = 1'b0;
    int extCount = 0;
    logic clkLineOut, clkLineOe_n, syncOut, syncOe_n, frameSignal;
    wire clkLine;
    wire syncLine;
    lmdt_cfg_type cfgIn;
    lmdt_wr_type wrIn;
    lmdt_level_type bp [4];
    lmdt_level_type seg [40];
    logic [2:0] volts;
    logic [1:0] probeRow;
    logic [5:0] probeCol;
    int fails, samples_checked;

    // The clock line carries our oscillator while driven, else the source.
    assign clkLine = clkLineOe_n ? extClk : clkLineOut;
    // The sync line is open drain with a pull-up.
    assign syncLine = (!syncOe_n || tbSyncLow) ? 1'b0 : 1'b1;

    // A 100 MHz system clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // The external source never stops once on, so no DC reaches the panel.
    always @(negedge clk) begin
        if (extOn) begin
            extCount <= (extCount == 9) ? 0 : extCount + 1;
            if (extCount == 9) begin
                extClk <= ~extClk;
            end
        end
    end

    lmdt_display_timing u_dut (.clk(clk), .rst_n(rst_n),
        .clock_source_select_pin(selPin), .clkLineIn(clkLine),
        .clkLineOut(clkLineOut), .clkLineOe_n(clkLineOe_n),
        .syncIn(syncLine), .syncOut(syncOut), .syncOe_n(syncOe_n),
        .cfgValid(cfgValid), .cfgIn(cfgIn), .wrValid(wrValid),
        .wrIn(wrIn), .backplane_outputs(bp), .segment_outputs(seg),
        .frameSignal(frameSignal));

    lmdt_panel_model u_panel (.backplanes(bp), .segments(seg),
        .probeRow(probeRow), .probeCol(probeCol), .voltsAcross(volts));

    // ==========================================================
    // Shared tasks
    task automatic check(input string name, input logic [15:0] exp,
                         input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    // Waiting is bounded so that a stuck sequencer shows as a mismatch.
    task automatic wait_bp(input int i, input lmdt_level_type lv);
        int n;
        n = 0;
        while (bp[i] !== lv && n < 2000) begin
            @(negedge clk);
            n++;
        end
        if (n == 2000) begin
            fails++;
            $display("Error backplane wait expected %0h seen %0h", lv, bp[i]);
        end
    endtask

    // A config restarts the scan, so row 0 shows three cycles later.
    task automatic set_cfg(input lmdt_mode_type m, input logic h);
        @(negedge clk);
        cfgValid = 1'b1;
        cfgIn = '{mode: m, halfBias: h};
        @(negedge clk);
        cfgValid = 1'b0;
        repeat (4) @(negedge clk);
    endtask

    task automatic write_byte(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk);
        wrValid = 1'b1;
        wrIn = '{addr: a, data: d};
        @(negedge clk);
        wrValid = 1'b0;
    endtask

    // Counts cycles of one whole half frame, skipping the partial one.
    task automatic measure_half(output int n);
        logic f;
        n = 0;
        f = frameSignal;
        while (frameSignal === f && n < 5000) begin
            @(negedge clk);
            n++;
        end
        n = 0;
        f = frameSignal;
        while (frameSignal === f && n < 5000) begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic report_and_stop;
        $display("Checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic test_default;
        int n;
        repeat (3) @(negedge clk);
        check("bp0 default", LV_LCD, bp[0]);
        check("bp3 default", LV_THIRD, bp[3]);
        check("clock line drive", 0, clkLineOe_n);
        measure_half(n);
        check("half frame osc", 16'(FRAME_DIV * OSC_HALF_CYCLES), 16'(n));
        $display("test_default done");
    endtask

    // Byte A5 in 1:4 fills column 0 rows with 1010 and column 1 with 0101.
    task automatic test_write_1to4;
        write_byte(6'h00, 8'hA5);
        set_cfg(MODE_1TO4, 1'b0);
        check("seg0 row0", LV_SS, seg[0]);
        check("seg1 row0", LV_TWOTHIRD, seg[1]);
        check("panel volts", 4, volts);
        wait_bp(1, LV_LCD);
        check("seg0 row1", LV_TWOTHIRD, seg[0]);
        check("seg1 row1", LV_SS, seg[1]);
        wait_bp(0, LV_SS);
        check("seg0 pol1", LV_LCD, seg[0]);
        check("bp1 pol1", LV_TWOTHIRD, bp[1]);
        $display("test_write_1to4 done");
    endtask

    task automatic test_static;
        set_cfg(MODE_STATIC, 1'b0);
        write_byte(6'h08, 8'h80);
        set_cfg(MODE_STATIC, 1'b0);
        check("bp0 static", LV_LCD, bp[0]);
        check("bp1 static", LV_LCD, bp[1]);
        check("bp3 static", LV_LCD, bp[3]);
        check("seg8 static", LV_SS, seg[8]);
        check("seg9 static", LV_LCD, seg[9]);
        $display("test_static done");
    endtask

    task automatic test_1to2_half;
        int bad;
        bad = 0;
        set_cfg(MODE_1TO2, 1'b1);
        check("bp1 half bias", LV_HALF, bp[1]);
        repeat (800) begin
            @(negedge clk);
            if (bp[0] !== bp[2] || bp[1] !== bp[3]) begin
                bad++;
            end
        end
        check("pairs 1:2", 0, 16'(bad));
        $display("test_1to2_half done");
    endtask

    task automatic test_1to3;
        int bad;
        bad = 0;
        set_cfg(MODE_1TO3, 1'b0);
        check("bp2 1:3", LV_THIRD, bp[2]);
        repeat (800) begin
            @(negedge clk);
            if (bp[3] !== bp[1]) begin
                bad++;
            end
        end
        check("bp3 as bp1", 0, 16'(bad));
        $display("test_1to3 done");
    endtask

    // Another device pulling sync low mid-frame forces a restart at row 0.
    task automatic test_sync;
        int n;
        set_cfg(MODE_1TO4, 1'b0);
        wait_bp(2, LV_LCD);
        tbSyncLow = 1'b1;
        n = 0;
        while (bp[0] !== LV_LCD && n < 12) begin
            @(negedge clk);
            n++;
        end
        tbSyncLow = 1'b0;
        check("sync realign", 1, 16'(n < 10));
        check("own sync low", 0, syncLine);
        $display("test_sync done");
    endtask

    task automatic test_external;
        int n;
        selPin = 1'b1;
        extOn = 1'b1;
        repeat (800) @(negedge clk);
        check("clock line input", 1, clkLineOe_n);
        measure_half(n);
        check("half frame ext", 16'(FRAME_DIV / 2 * 20), 16'(n));
        $display("test_external done");
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        fails = 0;
        samples_checked = 0;
        extOn = 1'b0;
        selPin = 1'b0;
        tbSyncLow = 1'b0;
        cfgValid = 1'b0;
        wrValid = 1'b0;
        cfgIn = CFG_RESET;
        wrIn = '0;
        probeRow = 2'h0;
        probeCol = 6'h00;
        rst_n = 1'b0;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        test_default();
        test_write_1to4();
        test_static();
        test_1to2_half();
        test_1to3();
        test_sync();
        test_external();
        report_and_stop();
    end

    // The scenarios need about 4200 cycles; allow more than four times that.
    initial begin
        #200000;
        fails++;
        $display("Error watchdog expected done seen timeout");
        report_and_stop();
    end
endmodule
